// ### logic/uhlc_map.svh
// offsets, field positions, reset values and timing counts of the list control block
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef UHLC_MAP_SVH
`define UHLC_MAP_SVH
`define UHLC_ADR_CTRL 8'h00
`define UHLC_ADR_STAT 8'h04
`define UHLC_CTRL_W 11
`define UHLC_CTRL_RST 11'h000
`define UHLC_BIT_CBR_LO 0
`define UHLC_BIT_PLE 2
`define UHLC_BIT_IE 3
`define UHLC_BIT_CLE 4
`define UHLC_BIT_BLE 5
`define UHLC_BIT_HFS_LO 6
`define UHLC_BIT_IR 8
`define UHLC_BIT_RWC 9
`define UHLC_BIT_RWE 10
`define UHLC_CLK_KHZ 20000
`define UHLC_SOF_DLY_US 1000
`define UHLC_FRAME_US 1000
`define UHLC_SOF_DLY_CYC ((`UHLC_SOF_DLY_US * `UHLC_CLK_KHZ) / 1000)
`define UHLC_FRAME_CYC ((`UHLC_FRAME_US * `UHLC_CLK_KHZ) / 1000)
`endif

// ### logic/uhlc_pkg.sv
// types of the list control block
// assumes uhlc_map.svh for offsets and counts
package uhlc_pkg;
  typedef enum logic [1:0] {
    UHLC_HFS_RESET = 2'h0,
    UHLC_HFS_RESUME = 2'h1,
    UHLC_HFS_OPER = 2'h2,
    UHLC_HFS_SUSPEND = 2'h3
  } uhlc_hfs_t;
  // gray along idle -> periodic -> non-periodic
  typedef enum logic [1:0] {
    UHLC_PH_IDLE = 2'h0,
    UHLC_PH_PERIOD = 2'h1,
    UHLC_PH_NONPER = 2'h3
  } uhlc_phase_t;
  typedef struct packed {
    logic [10:0] ctl;
    logic rsm_meta;
    logic rsm_sync;
    uhlc_phase_t phase;
    logic [1:0] ctrl_cnt;
    logic snap_ie;
    logic [15:0] dly_cnt;
    logic [15:0] frm_cnt;
    logic prev_op;
    logic sof_run;
    logic sof;
    logic serve_p;
    logic serve_c;
    logic serve_b;
    logic ack;
    logic [31:0] dat;
  } uhlc_state_t;
endpackage : uhlc_pkg

// ### logic/uhlc_top.sv
// list control register and per-frame list selection of a usb host controller
// assumes a classic wishbone master, a traversal engine on core_clk_i, and
// an asynchronous resume indication from the downstream ports
//
// Overview of operation
// RQ1 - bulk list served from next frame when set
// RQ2 - bulk list stops after next sof when cleared
// RQ3 - bulk enable sampled at every service decision
// RQ4 - driver advances bulk pointer before re-enabling
// RQ5 - control list served from next frame when set
// RQ6 - control list stops after next sof when cleared
// RQ7 - control enable checked at every service decision
// RQ8 - driver advances control pointer before re-enabling
// RQ9 - iso enable tested at each iso descriptor
// RQ10 - iso off abandons periodic, goes non-periodic
// RQ11 - iso enable set acts only next frame
// RQ12 - periodic enable acts from next frame
// RQ13 - periodic enable checked before periodic traversal
// RQ14 - control count compared with ratio before serving
// RQ15 - ratio codes give one, two, three to one
// RQ16 - control count kept across frame boundaries
// RQ17 - driver rewrites ratio after reset
// RQ18 - ratio field resets to zero, software writable
// RQ19 - functional state encoding, resets to usb reset
// RQ20 - sof starts one millisecond after entering operational
// RQ21 - suspend moves to resume on downstream resume
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "uhlc_map.svh"
module uhlc_top import uhlc_pkg::*; #(
  parameter int SOF_DLY_CYC = `UHLC_SOF_DLY_CYC,
  parameter int FRAME_CYC = `UHLC_FRAME_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic resume_detect_i,
  input wire logic iso_ed_found_i,
  input wire logic periodic_done_i,
  input wire logic ctrl_ed_done_i,
  input wire logic bulk_ed_done_i,
  output logic sof_o,
  output logic serve_periodic_o,
  output logic serve_ctrl_o,
  output logic serve_bulk_o,
  output logic [1:0] host_functional_state_o
);

  localparam logic [15:0] SOF_DLY_LAST = 16'(SOF_DLY_CYC - 1);
  localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYC - 1);

  uhlc_state_t st_r;
  uhlc_state_t st_nxt;

  // byte-lane merge of a write into the stored control bits
  function automatic logic [10:0] merge_ctl(input logic [10:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [10:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      res[10:8] = wd[10:8];
    end
    return res;
  endfunction : merge_ctl

  // control gets one more turn while count is within ratio code
  function automatic logic ctrl_turn(input logic [1:0] cnt, input logic [1:0] ratio);
    return ({1'b0, cnt} <= {1'b0, ratio}); // RQ15
  endfunction : ctrl_turn

  logic periodic_list_on;
  logic ie;
  logic cle;
  logic bulk_list_on;
  logic [1:0] ratio;
  logic op_now;
  logic pick_c;

  always_comb begin
    st_nxt = st_r;
    periodic_list_on = st_r.ctl[`UHLC_BIT_PLE];
    ie = st_r.ctl[`UHLC_BIT_IE];
    cle = st_r.ctl[`UHLC_BIT_CLE];
    bulk_list_on = st_r.ctl[`UHLC_BIT_BLE];
    ratio = st_r.ctl[`UHLC_BIT_CBR_LO +: 2];
    op_now = 1'b0;
    pick_c = 1'b0;
    if (ce_i) begin
      st_nxt.sof = 1'b0;
      st_nxt.rsm_meta = resume_detect_i;
      st_nxt.rsm_sync = st_r.rsm_meta;
      // register bus: one wait state, ack drops the cycle after
      if (wb_cyc_i && wb_stb_i && !st_r.ack) begin
        st_nxt.ack = 1'b1;
        st_nxt.dat = 32'h0000_0000;
        if (wb_adr_i == `UHLC_ADR_CTRL) begin
          st_nxt.dat = {21'h00_0000, st_r.ctl};
          if (wb_we_i) begin
            st_nxt.ctl = merge_ctl(st_r.ctl, wb_dat_i, wb_sel_i); // RQ18
          end
        end else if (wb_adr_i == `UHLC_ADR_STAT) begin
          st_nxt.dat = {24'h00_0000, st_r.sof_run, st_r.phase, st_r.ctrl_cnt,
                        st_r.serve_p, st_r.serve_c, st_r.serve_b};
        end
      end else begin
        st_nxt.ack = 1'b0;
      end
      // hardware resume wins over a same-cycle software write
      if (st_r.ctl[`UHLC_BIT_HFS_LO +: 2] == UHLC_HFS_SUSPEND && st_r.rsm_sync) begin
        st_nxt.ctl[`UHLC_BIT_HFS_LO +: 2] = UHLC_HFS_RESUME; // RQ21
      end
      op_now = (st_nxt.ctl[`UHLC_BIT_HFS_LO +: 2] == UHLC_HFS_OPER);
      st_nxt.prev_op = op_now;
      if (!op_now) begin
        st_nxt.sof_run = 1'b0;
        st_nxt.phase = UHLC_PH_IDLE;
        st_nxt.serve_p = 1'b0;
        st_nxt.serve_c = 1'b0;
        st_nxt.serve_b = 1'b0;
      end else if (!st_r.prev_op) begin
        st_nxt.dly_cnt = SOF_DLY_LAST; // RQ20
        st_nxt.sof_run = 1'b0;
      end else if (!st_r.sof_run) begin
        if (st_r.dly_cnt == 16'h0000) begin
          st_nxt.sof_run = 1'b1; // RQ20
          st_nxt.frm_cnt = 16'h0000;
        end else begin
          st_nxt.dly_cnt = st_r.dly_cnt - 16'h0001;
        end
      end else begin
        if (st_r.frm_cnt == 16'h0000) begin
          // new frame: periodic and iso enables read here, count deliberately kept
          st_nxt.sof = 1'b1;
          st_nxt.frm_cnt = FRAME_LAST;
          st_nxt.snap_ie = ie; // RQ11
          st_nxt.phase = periodic_list_on ? UHLC_PH_PERIOD : UHLC_PH_NONPER; // RQ12 RQ13
        end else begin
          st_nxt.frm_cnt = st_r.frm_cnt - 16'h0001;
          case (st_r.phase)
            UHLC_PH_PERIOD: begin
              if (periodic_done_i) begin
                st_nxt.phase = UHLC_PH_NONPER;
              end else if (iso_ed_found_i && !(ie && st_r.snap_ie)) begin
                st_nxt.phase = UHLC_PH_NONPER; // RQ9 RQ10 RQ11
              end
            end
            UHLC_PH_NONPER: begin
              if (st_r.serve_c && ctrl_ed_done_i && st_r.ctrl_cnt != 2'h3) begin
                st_nxt.ctrl_cnt = st_r.ctrl_cnt + 2'h1; // RQ16
              end
              if (st_r.serve_b && bulk_ed_done_i) begin
                st_nxt.ctrl_cnt = 2'h0;
              end
            end
            default: begin
              st_nxt.phase = UHLC_PH_IDLE;
            end
          endcase
        end
        // live control and bulk enables at every decision; a cleared cle or bulk_list_on bit is honoured at once
        pick_c = cle && (!bulk_list_on || ctrl_turn(st_nxt.ctrl_cnt, ratio)); // RQ14 RQ7
        st_nxt.serve_p = (st_nxt.phase == UHLC_PH_PERIOD);
        st_nxt.serve_c = (st_nxt.phase == UHLC_PH_NONPER) && pick_c; // RQ5 RQ6
        st_nxt.serve_b = (st_nxt.phase == UHLC_PH_NONPER) && bulk_list_on && !pick_c; // RQ1 RQ2 RQ3
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0; // RQ18 RQ19
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign sof_o = st_r.sof;
  assign serve_periodic_o = st_r.serve_p;
  assign serve_ctrl_o = st_r.serve_c;
  assign serve_bulk_o = st_r.serve_b;
  assign host_functional_state_o = st_r.ctl[`UHLC_BIT_HFS_LO +: 2];

endmodule : uhlc_top

// ### tb/uhlc_checker.sv
// port checker of the list control block
// assumes a bind to uhlc_top, one clock
`timescale 1ns/1ps
module uhlc_checker #(
  parameter int SOF_DLY_CYC = 20,
  parameter int FRAME_CYC = 50
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic resume_detect_i,
  input wire logic iso_ed_found_i,
  input wire logic periodic_done_i,
  input wire logic sof_o,
  input wire logic serve_periodic_o,
  input wire logic serve_ctrl_o,
  input wire logic serve_bulk_o,
  input wire logic [1:0] host_functional_state_o
);
  logic [15:0] gap_r;
  logic seen_r;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // first sof after entering operational is exempt
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      // frame counter is frozen while the clock enable is low
      if (ce_i) gap_r <= sof_o ? 16'h0000 : gap_r + 16'h0001;
      seen_r <= host_functional_state_o == 2'h2 && (seen_r || sof_o);
    end
  end
  sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse; endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  property p_rst; $past(rst_i) |-> host_functional_state_o == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("state not reset");
  property p_one; $onehot0({serve_periodic_o, serve_ctrl_o, serve_bulk_o}); endproperty
  a_one: assert property (p_one) else $error("two lists served");
  property p_sof_op; sof_o |-> host_functional_state_o == 2'h2; endproperty
  a_sof_op: assert property (p_sof_op) else $error("sof off state");
  property p_gap; ce_i && sof_o && seen_r |-> gap_r == FRAME_CYC - 1; endproperty
  a_gap: assert property (p_gap) else $error("frame length");
  property p_per_go; $rose(serve_periodic_o) |-> sof_o; endproperty
  a_per_go: assert property (p_per_go) else $error("periodic mid frame");
  property p_per_end;
    $fell(serve_periodic_o) && host_functional_state_o == 2'h2
      |-> $past(periodic_done_i || iso_ed_found_i) || sof_o;
  endproperty
  a_per_end: assert property (p_per_end) else $error("periodic cut");
  property p_wake;
    $rose(resume_detect_i) && host_functional_state_o == 2'h3
      |-> ##[1:5] host_functional_state_o == 2'h1;
  endproperty
  a_wake: assert property (p_wake) else $error("no resume");
endmodule : uhlc_checker
bind uhlc_top uhlc_checker #(.SOF_DLY_CYC(SOF_DLY_CYC), .FRAME_CYC(FRAME_CYC)) i_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .resume_detect_i(resume_detect_i), .iso_ed_found_i(iso_ed_found_i),
  .periodic_done_i(periodic_done_i), .sof_o(sof_o), .serve_periodic_o(serve_periodic_o),
  .serve_ctrl_o(serve_ctrl_o), .serve_bulk_o(serve_bulk_o),
  .host_functional_state_o(host_functional_state_o));

// ### tb/uhlc_drv_model.sv
// driver software model: classic wishbone master
// assumes one transfer at a time; lists never edited, so no pointer fixups
`timescale 1ns/1ps
module uhlc_drv_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o = 1'b0,
  output logic stb_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [7:0] adr_o = 8'h00,
  output logic [3:0] sel_o = 4'hF,
  output logic [31:0] dat_o = 32'h0000_0000
);
  // set when a transfer never got its ack; the bench counts it as a mismatch
  logic hung = 1'b0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'h3, w, a, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    if (n >= 50) hung = 1'b1;
    q = dat_i;
    {cyc_o, stb_o, dat_o} <= {2'h0, ~d};
  endtask : xfer
endmodule : uhlc_drv_model

// ### tb/testbench.sv
// bench of the list control block
// assumes sof delay 20 and frame 50 clocks
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module testbench;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic res_r = 1'b0;
  logic ce_r = 1'b1;
  logic [3:0] eng_r = 4'h0;
  logic cyc, stb, we, ack, sof, sp, sc, sb;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rdat, q;
  logic [1:0] hfs;
  int fails = 0;
  int checks_done = 0;
  int n, c;
  initial forever #25 core_clk_i = ~core_clk_i;
  uhlc_top #(.SOF_DLY_CYC(20), .FRAME_CYC(50)) i_uhlc_top (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .ce_i(ce_r), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .resume_detect_i(res_r), .iso_ed_found_i(eng_r[3]), .periodic_done_i(eng_r[2]),
    .ctrl_ed_done_i(eng_r[1]), .bulk_ed_done_i(eng_r[0]), .sof_o(sof),
    .serve_periodic_o(sp), .serve_ctrl_o(sc), .serve_bulk_o(sb),
    .host_functional_state_o(hfs));
  uhlc_drv_model i_uhlc_drv_model (.clk_i(core_clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  task automatic wr(input logic [31:0] d);
    i_uhlc_drv_model.xfer(1'b1, 8'h00, d, q);
    pulse(4'h0);
  endtask : wr
  task automatic pulse(input logic [3:0] m);
    eng_r <= m;
    @(posedge core_clk_i);
    eng_r <= 4'h0;
    @(posedge core_clk_i);
  endtask : pulse
  task automatic wsof;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (sof !== 1'b1 && n < 200);
    `CHK("sof seen", 1'b1, sof)
  endtask : wsof
  task automatic t_regs;
    i_uhlc_drv_model.xfer(1'b0, 8'h00, 32'h0000_0000, q);
    `CHK("reset ctl", 32'h0000_0000, q)
    wr(32'hFFFF_F83F);
    i_uhlc_drv_model.xfer(1'b0, 8'h00, 32'h0000_0000, q);
    `CHK("ctl rw", 32'h0000_003F, q)
    i_uhlc_drv_model.xfer(1'b0, 8'h08, 32'h0000_0000, q);
    `CHK("unmapped", 32'h0000_0000, q)
    $display("registers done");
  endtask : t_regs
  task automatic t_frames;
    wr(32'h0000_0084);
    wsof;
    `CHK("sof delay", 1'b1, n >= 17 && n <= 24)
    `CHK("periodic", 1'b1, sp)
    wr(32'h0000_008C);
    pulse(4'h8);
    `CHK("iso new", 1'b0, sp)
    wsof;
    pulse(4'h8);
    `CHK("iso on", 1'b1, sp)
    $display("frames done");
  endtask : t_frames
  task automatic t_ratios;
    for (logic [1:0] r = 0; r < 3; r++) begin
      wr({30'h0000_002C, r});
      wsof;
      pulse(4'h0);
      c = 0;
      while (sc === 1'b1 && c < 5) begin
        pulse(4'h2);
        c++;
        if (c == 1) wsof;
        if (c == 1) pulse(4'h0);
      end
      `CHK("ctrl count", r + 1, c)
      `CHK("bulk turn", 1'b1, sb)
      if (r < 2) pulse(4'h1);
    end
    wr(32'h0000_0090);
    `CHK("bulk off", 2'h2, {sc, sb})
    wr(32'h0000_0080);
    `CHK("ctrl off", 1'b0, sc)
    $display("ratios done");
  endtask : t_ratios
  // clock enable low: no frame may advance, no sof or serve output may move
  task automatic t_freeze;
    logic [3:0] s;
    ce_r <= 1'b0;
    @(posedge core_clk_i);
    s = {sof, sp, sc, sb};
    c = 0;
    repeat (120) begin
      @(posedge core_clk_i);
      if ({sof, sp, sc, sb} !== s) c++;
    end
    ce_r <= 1'b1;
    `CHK("frozen", 0, c)
    wsof;
    $display("freeze done");
  endtask : t_freeze
  task automatic t_resume;
    wr(32'h0000_00C0);
    res_r <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    `CHK("resume", 2'h1, hfs)
    $display("resume done");
  endtask : t_resume
  task automatic give_verdict;
    if (i_uhlc_drv_model.hung) fails++;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_frames;
    t_ratios;
    t_freeze;
    t_resume;
    give_verdict;
  end
  initial begin
    #1000000;
    fails++;
    give_verdict;
  end
endmodule : testbench
